// file: cmd_interp_regs.svh
// Register offsets, field positions, codes and sizes of the command interpreter
`ifndef CMD_INTERP_REGS_SVH
`define CMD_INTERP_REGS_SVH
// ***************************************************
// Register byte offsets
// ***************************************************
`define OFS_CMD_LO     8'h00
`define OFS_CMD_HI     8'h04
`define OFS_CTRL       8'h08
`define OFS_STATUS     8'h0c
`define OFS_RPT_LO     8'h10
`define OFS_RPT_HI     8'h14
// ***************************************************
// Field positions
// ***************************************************
`define CTRL_GO_BIT    0
`define KEEP_BIT       7
`define LAST_BIT       7
// ***************************************************
// Command codes and completion codes
// ***************************************************
`define OP_DUMP        8'h4c
`define OP_VEC         8'h0d
`define OP_WLOAD       8'h1d
`define OP_WDUMP       8'h2d
`define OP_SIZE        8'h3d
`define OP_IDSW        8'h4d
`define OP_RSV         8'h5d
`define OP_REL         8'h6d
`define OP_DVERIFY     8'h0f
`define OP_DPAT        8'h1f
`define OP_DECHO       8'h2f
`define CC_OK          8'h00
`define CC_DIAG        8'h32
`define CC_ADDR        8'h26
`define CC_BADCMD      8'h20
`define CC_RSVBUSY     8'h21
`define CC_RELBAD      8'h22
`define CC_NOBLK       8'h23
`define CC_NOROOM      8'h24
`define CC_RAMFAIL     8'h73
`define ST_FAIL_BYTE   8'hff
// ***************************************************
// Memory map and sizes
// ***************************************************
`define ROM_LAST       16'h3ffe
`define RAM_FIRST      16'h9800
`define RAM_LAST       16'ha7fe
`define RAM_END        16'ha800
`define RSV_BASE       16'h9c00
`define ROM_BYTES      16'h4000
`define RAM_BYTES      16'h1000
`define ROM_FILL       16'h0000
`define RAM_WORDS      2048
`define BLK_SLOTS      4
`define DIAG_PAT       32'h00ff55aa
`endif

// file: cmd_interp_pkg.sv
// Types shared by the command interpreter
package cmd_interp_pkg;
   // Five-byte command block, byte 0 in the top field
   typedef struct packed {
      logic [7:0] op;  // Modifier high nibble, group low
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
   } cmd_t;
   // Six-byte report, index 0 is byte 0
   typedef logic [5:0][7:0] rpt_t;
   // Block of call data arriving from the network side
   typedef struct packed {
      logic        valid;
      logic [1:0]  kind;  // 0 progress, 1 line equipment, 2 charge
      logic        last;  // Last block of this information
      logic [14:0] len;   // Byte count held in the block
   } netblk_t;
   // Interpreter states
   typedef enum logic [3:0] {
      S_TW, S_TA, S_TC, S_IDLE, S_V1, S_V2, S_VW, S_WD
   } state_t;
endpackage

// file: host_command_interpreter.sv
// Host command interpreter with classic Wishbone register access
// Functional notes
// - Byte 2 top bit keeps buffer; rest block
// - Dump report: echo, flag and count, code
// - Last-block flag as sent with network block; always set for charge
// - Subopcode 01 dumps line equipment information
// - Subopcode 02 dumps single call charge block
// - Free dump buffers on open or reset
// - Immediate modifiers 0..6 decoded, 7 reserved
// - Vector call reads two words, echoes, code 00
// - Word load only into RAM range
// - Word dump from ROM or RAM range
// - Size command reports ROM and RAM bytes
// - Switch value returned in bytes 1 and 3
// - Reserve refused while area still reserved
// - Granted reserve reports length and start
// - Release rejected on wrong start address
// - Verify pattern, code 32 on mismatch
// - Return fixed pattern, code zero
// - Echo five bytes, code zero; 3..7 unused
// - Self-test on reset; fail lamp and report
`include "cmd_interp_regs.svh"
module host_command_interpreter
   import cmd_interp_pkg::*;
(
   input  wire logic        clk_i,       // 100 MHz clock
   input  wire logic        rst_i,       // Synchronous reset
   input  wire logic        wb_cyc_i,    // Wishbone cycle
   input  wire logic        wb_stb_i,    // Wishbone strobe
   input  wire logic        wb_we_i,     // Write enable
   input  wire logic [7:0]  wb_adr_i,    // Byte address
   input  wire logic [3:0]  wb_sel_i,    // Byte lanes
   input  wire logic [31:0] wb_dat_i,    // Write data
   output logic      [31:0] wb_dat_o,    // Read data
   output logic             wb_ack_o,    // Acknowledge
   input  wire logic [7:0]  id_sw_i,     // Identification switches
   input  wire logic        open_i,      // New open command pulse
   input  wire netblk_t     netblk_i,    // Call data from network
   output logic             vec_req_o,   // Start routine pulse
   output logic      [15:0] vec_ws_o,    // Workspace address
   output logic      [15:0] vec_pc_o,    // Routine entry address
   input  wire logic        vec_done_i,  // Routine returned
   output logic             fail_led_o   // Self-test fail lamp
);
   // ***************************************************
   // Helpers
   // ***************************************************
   // Address lies in RAM window
   function automatic logic in_ram(input logic [15:0] a);
      return (a >= `RAM_FIRST) && (a <= `RAM_LAST);
   endfunction
   // Word index of a RAM address
   function automatic logic [10:0] ram_ix(input logic [15:0] a);
      logic [15:0] d;
      d = a - `RAM_FIRST;
      return d[11:1];
   endfunction
   // Self-test pattern: address or its complement
   function automatic logic [15:0] pat(input logic [10:0] i,
                                       input logic ph);
      logic [15:0] a;
      a = `RAM_FIRST + {4'h0, i, 1'b0};
      return ph ? ~a : a;
   endfunction

   // ***************************************************
   // State
   // ***************************************************
   state_t      state_q;            // Interpreter state
   cmd_t        cmd_q;              // Command block
   rpt_t        rpt_q;              // Completion report
   logic        start_q;            // Go pulse from bus
   logic        done_q;             // Report ready
   logic        fail_q;             // Fail lamp
   logic        ph_q;               // Self-test pass
   logic [10:0] cnt_q;              // Self-test word index
   logic        rsv_q;              // Area reserved
   logic [15:0] rsv_len_q;          // Reserved length
   logic        ack_q;              // Bus acknowledge
   logic [31:0] rdat_q;             // Bus read data
   logic [15:0] ram [`RAM_WORDS];   // Board RAM
   logic [15:0] ram_q;              // Registered RAM read
   logic        ram_we;             // RAM write strobe
   logic [10:0] ram_a;              // RAM word index
   logic [15:0] ram_wd;             // RAM write data
   logic [14:0] blk_len_q [3][`BLK_SLOTS]; // Block sizes
   logic        blk_last_q [3][`BLK_SLOTS]; // Final flags
   logic [2:0]  blk_cnt_q [3];      // Stored blocks per kind
   logic        busy;               // Command in progress
   logic [15:0] addr;               // Bytes 1,2 address
   logic [1:0]  dk;                 // Dump kind
   logic [6:0]  dn;                 // Dump block number
   logic [14:0] dreq;               // Requested count
   logic [14:0] dlen;               // Stored block length
   logic        dfree;              // Free kind after dump
   logic        wr_cyc;             // Bus write this cycle
   logic        rd_cyc;             // Bus read this cycle

   assign busy   = (state_q != S_IDLE) || start_q;
   assign addr   = {cmd_q.b1, cmd_q.b2};
   assign dk     = cmd_q.b1[1:0];
   assign dn     = cmd_q.b2[6:0];
   assign dreq   = {cmd_q.b3[6:0], cmd_q.b4};
   assign dlen   = blk_len_q[(dk > 2'd2) ? 2'd0 : dk][dn[1:0]];
   assign wr_cyc = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i;
   assign rd_cyc = wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i;
   assign fail_led_o = fail_q;
   assign wb_ack_o   = ack_q;
   assign wb_dat_o   = rdat_q;

   // ***************************************************
   // Wishbone slave
   // ***************************************************
   // One-cycle answer, released the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end

   // Read mux; unmapped reads as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (rd_cyc) begin
         case (wb_adr_i)
            `OFS_CMD_LO: rdat_q <= {cmd_q.b3, cmd_q.b2, cmd_q.b1, cmd_q.op};
            `OFS_CMD_HI: rdat_q <= {24'h000000, cmd_q.b4};
            `OFS_STATUS: rdat_q <= {28'h0000000, rsv_q, fail_q, done_q, busy};
            `OFS_RPT_LO: rdat_q <= {rpt_q[3], rpt_q[2], rpt_q[1], rpt_q[0]};
            `OFS_RPT_HI: rdat_q <= {16'h0000, rpt_q[5], rpt_q[4]};
            default:     rdat_q <= 32'h0000_0000;
         endcase
      end
   end

   // Command block; held while busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q <= '0;
      end else if (wr_cyc && !busy) begin
         if (wb_adr_i == `OFS_CMD_LO) begin
            if (wb_sel_i[0]) cmd_q.op <= wb_dat_i[7:0];
            if (wb_sel_i[1]) cmd_q.b1 <= wb_dat_i[15:8];
            if (wb_sel_i[2]) cmd_q.b2 <= wb_dat_i[23:16];
            if (wb_sel_i[3]) cmd_q.b3 <= wb_dat_i[31:24];
         end else if (wb_adr_i == `OFS_CMD_HI && wb_sel_i[0]) begin
            cmd_q.b4 <= wb_dat_i[7:0];
         end
      end
   end

   // Go pulse; ignored while busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_q <= 1'b0;
      end else begin
         start_q <= wr_cyc && !busy && (wb_adr_i == `OFS_CTRL)
                    && wb_sel_i[0] && wb_dat_i[`CTRL_GO_BIT];
      end
   end

   // ***************************************************
   // Board RAM
   // ***************************************************
   // Port steering by state
   always_comb begin
      ram_we = 1'b0;
      ram_a  = ram_ix(addr);
      ram_wd = {cmd_q.b3, cmd_q.b4};
      case (state_q)
         S_TW: begin
            ram_we = 1'b1;
            ram_a  = cnt_q;
            ram_wd = pat(cnt_q, ph_q);
         end
         S_TA: ram_a = cnt_q;
         S_V1: ram_a = ram_ix(addr) + 11'd1;
         S_IDLE: begin
            ram_we = start_q && (cmd_q.op == `OP_WLOAD) && in_ram(addr);
         end
         default: ram_a = ram_ix(addr);
      endcase
   end

   // Single port, registered read
   always_ff @(posedge clk_i) begin
      if (ram_we) begin
         ram[ram_a] <= ram_wd;
      end
      ram_q <= ram[ram_a];
   end

   // ***************************************************
   // Call data buffers
   // ***************************************************
   // Free on open, reset or dump; new block wins
   assign dfree = (state_q == S_IDLE) && start_q && (cmd_q.op == `OP_DUMP)
                  && !cmd_q.b2[`KEEP_BIT] && (cmd_q.b1 <= 8'h02);
   always_ff @(posedge clk_i) begin
      logic [2:0] base;
      base = 3'd0;
      for (int k = 0; k < 3; k++) begin
         base = blk_cnt_q[k];
         if (rst_i || open_i || (dfree && dk == k[1:0])) begin
            base = 3'd0;
         end
         if (netblk_i.valid && netblk_i.kind == k[1:0]) begin
            if (k == 2) begin
               blk_len_q[k][0]  <= netblk_i.len;
               blk_last_q[k][0] <= 1'b1;
               base = 3'd1;
            end else if (base < 3'(`BLK_SLOTS)) begin
               blk_len_q[k][base[1:0]]  <= netblk_i.len;
               blk_last_q[k][base[1:0]] <= netblk_i.last;
               base = base + 3'd1;
            end
         end
         blk_cnt_q[k] <= base;
      end
   end

   // ***************************************************
   // Interpreter
   // ***************************************************
   // Self-test, command decode and report
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q   <= S_TW;
         cnt_q     <= 11'd0;
         ph_q      <= 1'b0;
         fail_q    <= 1'b1;
         done_q    <= 1'b0;
         rpt_q     <= '0;
         rsv_q     <= 1'b0;
         rsv_len_q <= 16'h0000;
         vec_req_o <= 1'b0;
         vec_ws_o  <= 16'h0000;
         vec_pc_o  <= 16'h0000;
      end else begin
         vec_req_o <= 1'b0;
         case (state_q)
            // Write pass of the RAM test
            S_TW: begin
               cnt_q <= cnt_q + 11'd1;
               if (cnt_q == 11'(`RAM_WORDS - 1)) state_q <= S_TA;
            end
            // Read address of the check pass
            S_TA: state_q <= S_TC;
            // Compare and report the first bad word
            S_TC: begin
               cnt_q   <= cnt_q + 11'd1;
               state_q <= S_TA;
               if (ram_q != pat(cnt_q, ph_q)) begin
                  // Bad bits and failing address, high byte first
                  rpt_q[0] <= `ST_FAIL_BYTE;
                  {rpt_q[1], rpt_q[2]} <= ram_q ^ pat(cnt_q, ph_q);
                  {rpt_q[3], rpt_q[4]} <= `RAM_FIRST + {4'h0, cnt_q, 1'b0};
                  rpt_q[5] <= `CC_RAMFAIL;
                  done_q  <= 1'b1;
                  state_q <= S_IDLE;
               end else if (cnt_q == 11'(`RAM_WORDS - 1)) begin
                  ph_q    <= 1'b1;
                  state_q <= ph_q ? S_IDLE : S_TW;
                  fail_q  <= ph_q ? 1'b0 : 1'b1;
               end
            end
            // Decode a new command block
            S_IDLE: begin
               if (start_q) begin
                  done_q <= 1'b1;
                  rpt_q  <= {`CC_OK, cmd_q.b4, cmd_q.b3, cmd_q.b2,
                             cmd_q.b1, cmd_q.op};
                  case (cmd_q.op)
                     `OP_DUMP: begin
                        if (cmd_q.b1 > 8'h02) begin
                           rpt_q[5] <= `CC_BADCMD;
                        end else if ({1'b0, dn} >= {5'd0, blk_cnt_q[dk]}) begin
                           rpt_q[5] <= `CC_NOBLK;
                        end else begin
                           {rpt_q[3], rpt_q[4]} <=
                              {blk_last_q[dk][dn[1:0]],
                               (dreq < dlen) ? dreq : dlen};
                        end
                     end
                     `OP_VEC: begin
                        if (in_ram(addr)) begin
                           done_q  <= 1'b0;
                           state_q <= S_V1;
                        end else begin
                           rpt_q[5] <= `CC_ADDR;
                        end
                     end
                     `OP_WLOAD: begin
                        if (!in_ram(addr)) rpt_q[5] <= `CC_ADDR;
                     end
                     `OP_WDUMP: begin
                        done_q  <= 1'b0;
                        state_q <= S_WD;
                     end
                     `OP_SIZE: begin
                        {rpt_q[1], rpt_q[2]} <= `ROM_BYTES;
                        {rpt_q[3], rpt_q[4]} <= `RAM_BYTES;
                     end
                     `OP_IDSW: begin
                        rpt_q[1] <= id_sw_i;
                        rpt_q[3] <= id_sw_i;
                     end
                     `OP_RSV: begin
                        if (rsv_q) begin
                           rpt_q[5] <= `CC_RSVBUSY;
                        end else if (addr == 16'h0000 ||
                                     addr > (`RAM_END - `RSV_BASE)) begin
                           rpt_q[5] <= `CC_NOROOM;
                        end else begin
                           rsv_q     <= 1'b1;
                           rsv_len_q <= addr;
                           {rpt_q[3], rpt_q[4]} <= `RSV_BASE;
                        end
                     end
                     `OP_REL: begin
                        if (!rsv_q || addr != `RSV_BASE) begin
                           rpt_q[5] <= `CC_RELBAD;
                        end else begin
                           rsv_q <= 1'b0;
                        end
                     end
                     `OP_DVERIFY: begin
                        if ({cmd_q.b4, cmd_q.b3, cmd_q.b2, cmd_q.b1}
                            != `DIAG_PAT) rpt_q[5] <= `CC_DIAG;
                     end
                     `OP_DPAT: begin
                        {rpt_q[4], rpt_q[3], rpt_q[2], rpt_q[1]} <= `DIAG_PAT;
                     end
                     `OP_DECHO: begin
                        rpt_q[5] <= `CC_OK;
                     end
                     default: rpt_q[5] <= `CC_BADCMD;
                  endcase
               end else begin
                  done_q <= done_q;
               end
            end
            // Workspace word in hand, read entry word
            S_V1: begin
               vec_ws_o <= ram_q;
               state_q  <= S_V2;
            end
            // Entry word in hand, start routine
            S_V2: begin
               vec_pc_o  <= ram_q;
               vec_req_o <= 1'b1;
               state_q   <= S_VW;
            end
            // Wait for the routine to return
            S_VW: begin
               if (vec_done_i) begin
                  done_q  <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            // Word dump answer
            S_WD: begin
               done_q  <= 1'b1;
               state_q <= S_IDLE;
               if (in_ram(addr)) begin
                  {rpt_q[3], rpt_q[4]} <= ram_q;
               end else if (addr <= `ROM_LAST) begin
                  {rpt_q[3], rpt_q[4]} <= `ROM_FILL;
               end else begin
                  rpt_q[5] <= `CC_ADDR;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   sequence go_s(logic [7:0] c);
      state_q == S_IDLE && start_q && cmd_q.op == c;
   endsequence

   echo_byte0_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == S_IDLE && start_q |=> rpt_q[0] == $past(cmd_q.op))
      else $error("byte 0 not echoed");
   diag_pat_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_s(`OP_DPAT) |=> rpt_q[1] == 8'haa && rpt_q[4] == 8'h00 && rpt_q[5] == 8'h00)
      else $error("fixed pattern wrong");
   diag_verify_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_s(`OP_DVERIFY) ##0 (cmd_q.b1 != 8'haa || cmd_q.b4 != 8'h00)
      |=> rpt_q[5] == `CC_DIAG)
      else $error("pattern mismatch not flagged");
   rsv_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_s(`OP_RSV) ##0 rsv_q |=> rpt_q[5] == `CC_RSVBUSY && rsv_q)
      else $error("second reserve granted");
   id_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_s(`OP_IDSW) |=> rpt_q[1] == $past(id_sw_i) && rpt_q[3] == rpt_q[1])
      else $error("switch value not returned");
   size_rpt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_s(`OP_SIZE) |=> {rpt_q[1], rpt_q[2]} == `ROM_BYTES
      && {rpt_q[3], rpt_q[4]} == `RAM_BYTES && rpt_q[5] == 8'h00)
      else $error("size report wrong");
   wload_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_s(`OP_WLOAD) ##0 !in_ram(addr) |-> !ram_we ##1 rpt_q[5] == `CC_ADDR)
      else $error("illegal word load");
   open_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
      open_i && !netblk_i.valid |=> blk_cnt_q[0] == 3'd0 && blk_cnt_q[2] == 3'd0)
      else $error("buffers kept after open");
   vec_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_s(`OP_VEC) ##0 in_ram(addr) |=> ##2 vec_req_o ##1 !vec_req_o)
      else $error("vector call not started");
   test_lamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == S_TW || state_q == S_TA |-> fail_led_o)
      else $error("lamp off during self-test");
endmodule

// file: routine_runner.sv
// Model of the routine that a vector call starts, answering after a set delay
module routine_runner (
   input  wire logic        clk_i,      // Bench clock
   input  wire logic        rst_i,      // Synchronous reset
   input  wire logic        vec_req_i,  // Start pulse from the block
   input  wire logic [15:0] vec_ws_i,   // Workspace word
   input  wire logic [15:0] vec_pc_i,   // Entry word
   input  wire logic [7:0]  lat_i,      // Cycles until return
   output logic      [31:0] seen_o,     // Words captured at start
   output logic             vec_done_o  // Return pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;  // Cycles left to return
   // Capture vector words, count down, pulse return once
   always_ff @(posedge clk_i) begin
      vec_done_o <= 1'b0;
      if (rst_i) begin
         cnt    <= 0;
         seen_o <= '0;
      end else if (vec_req_i) begin
         cnt    <= int'(lat_i);
         seen_o <= {vec_ws_i, vec_pc_i};
      end else if (cnt == 1) begin
         cnt        <= 0;
         vec_done_o <= 1'b1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// file: testbench.sv
// Self-checking bench for the host command interpreter
`include "cmd_interp_regs.svh"
module testbench;
   import cmd_interp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************
   // Signals, clock and instances
   // ***************************************************
   logic        clk_i, rst_i, cyc, stb, we, ack, open, vreq, vdone, led;
   logic [7:0]  adr, idsw, lat;
   logic [31:0] wdat, rdat, seen;
   logic [15:0] ws, pc;
   netblk_t     nb;
   int          mismatches, checks_done;
   localparam logic [47:0] F = 48'hffffffffffff;  // Whole report
   localparam logic [47:0] C = 48'hff0000000000;  // Code byte only
   initial begin
      clk_i = 0;
      forever #5 clk_i = ~clk_i;
   end
   host_command_interpreter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .id_sw_i(idsw), .open_i(open), .netblk_i(nb), .vec_req_o(vreq),
      .vec_ws_o(ws), .vec_pc_o(pc), .vec_done_i(vdone), .fail_led_o(led));
   routine_runner far (.clk_i(clk_i), .rst_i(rst_i), .vec_req_i(vreq), .vec_ws_i(ws),
      .vec_pc_i(pc), .lat_i(lat), .seen_o(seen), .vec_done_o(vdone));
   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      {cyc, stb} <= 2'b00;
      if (ack !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
   endtask
   // Send a block, wait for done, compare masked report
   task automatic run(input cmd_t c, input logic [47:0] e, input logic [47:0] m);
      logic [31:0] lo, hi, q;
      int n;
      wb(1'b1, `OFS_CMD_LO, {c.b3, c.b2, c.b1, c.op}, q);
      wb(1'b1, `OFS_CMD_HI, {24'h0, c.b4}, q);
      wb(1'b1, `OFS_CTRL, 32'h1, q);
      n = 0;
      q = '0;
      while (q[1] !== 1'b1 && n < 200) begin
         wb(1'b0, `OFS_STATUS, 32'h0, q);
         n++;
      end
      if (q[1] !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
      wb(1'b0, `OFS_RPT_LO, 32'h0, lo);
      wb(1'b0, `OFS_RPT_HI, 32'h0, hi);
      chk({hi[15:0], lo} & m, e & m);
      $display("test %h done", c.op);
   endtask
   // Store one network block
   task automatic blk(input logic [1:0] k, input logic l, input logic [14:0] n);
      @(posedge clk_i);
      nb <= '{1'b1, k, l, n};
      @(posedge clk_i);
      nb <= '0;
   endtask
   // Lamp lit after reset, self-test ends, lamp goes out
   task automatic self_test;
      logic [31:0] q;
      int n;
      chk({47'h0, led}, 48'h1);
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 6000) begin
         wb(1'b0, `OFS_STATUS, 32'h0, q);
         n++;
      end
      if (q[0] !== 1'b0) begin
         mismatches++;
         tally_and_finish();
      end
      chk({47'h0, led}, 48'h0);
   endtask
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      {rst_i, cyc, stb, we, open, adr, wdat, nb} = '0;
      rst_i = 1;
      idsw = 8'ha5;
      lat = 8'd1;
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      self_test();
      run(40'h0faa55ff00, 48'h0000ff55aa0f, F);
      run(40'h0faa55ff01, 48'h3201ff55aa0f, F);
      run(40'h1f12345678, 48'h0000ff55aa1f, F);
      run(40'h2f12345678, 48'h00785634122f, F);
      run(40'h3f00000000, 48'h200000000000, C);
      run(40'h7d00000000, 48'h200000000000, C);
      run(40'h3d11223344, 48'h00001000403d, F);
      run(40'h4d00000000, 48'h0000a500a54d, F);
      run(40'h1d9a009b00, 48'h0, C);
      run(40'h1d9a02a000, 48'h0, C);
      run(40'h1da7fe1234, 48'h0, C);
      run(40'h1d90001234, 48'h260000000000, C);
      run(40'h1da8001234, 48'h260000000000, C);
      run(40'h2d9a000000, 48'h00009b009a2d, 48'hffffff0000ff);
      run(40'h2d3ffe0000, 48'h0, 48'hffffff000000);
      run(40'h2d40000000, 48'h260000000000, C);
      for (int i = 0; i < 2; i++) begin
         lat <= i ? 8'd40 : 8'd1;
         run(40'h0d9a000000, 48'h000000009a0d, F);
         chk({16'h0, seen}, 48'h00009b00a000);
      end
      run(40'h5d01000000, 48'h00009c00015d, F);
      run(40'h5d00200000, 48'h210000000000, C);
      run(40'h6d9c020000, 48'h220000000000, C);
      run(40'h6d9c000000, 48'h0, C);
      run(40'h5d00400000, 48'h00009c40005d, F);
      blk(2'd1, 1'b1, 15'd5);
      run(40'h4c01000003, 48'h00038000014c, F);
      run(40'h4c01000003, 48'h230000000000, C);
      run(40'h4c05000003, 48'h200000000000, C);
      blk(2'd0, 1'b0, 15'd2);
      for (int i = 0; i < 2; i++) run(40'h4c00800010, 48'h00020080004c, F);
      blk(2'd2, 1'b1, 15'd4);
      run(40'h4c02800004, 48'h00048080024c, F);
      @(posedge clk_i);
      open <= 1'b1;
      @(posedge clk_i);
      open <= 1'b0;
      run(40'h4c02000004, 48'h230000000000, C);
      blk(2'd0, 1'b1, 15'd3);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      self_test();
      run(40'h4c00000003, 48'h230000000000, C);
      run(40'h5d01000000, 48'h00009c00015d, F);
      tally_and_finish();
   end
endmodule
